// *** agr_pkg.sv ***
// constants and carrier types for the audio gain / agc register bank
package agr_pkg;

  // ----------------------------------------------------------------
  // apb carriers
  // ----------------------------------------------------------------
  localparam int AGR_ADDR_W = 8;

  typedef struct packed {
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [AGR_ADDR_W-1:0] paddr;
    logic [31:0]           pwdata;
  } agr_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } agr_apb_rsp_t;

  // ----------------------------------------------------------------
  // register indices and byte addresses (index times four)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_PLL_FRAC = 8'h1C;
  localparam logic [7:0] IDX_STEP_BIAS = 8'h1D;
  localparam logic [7:0] IDX_HANDSET = 8'h1E;
  localparam logic [7:0] IDX_CELL_BUZ = 8'h1F;
  localparam logic [7:0] ADDR_PLL_FRAC = {IDX_PLL_FRAC[5:0], 2'h0};
  localparam logic [7:0] ADDR_STEP_BIAS = {IDX_STEP_BIAS[5:0], 2'h0};
  localparam logic [7:0] ADDR_HANDSET = {IDX_HANDSET[5:0], 2'h0};
  localparam logic [7:0] ADDR_CELL_BUZ = {IDX_CELL_BUZ[5:0], 2'h0};

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int POS_PLL_FRAC = 2;
  localparam int POS_STEP_OFF = 11;
  localparam int POS_HYST = 9;
  localparam int POS_HED_BIAS = 7;
  localparam int POS_HND_BIAS = 6;
  localparam int POS_SC_FLAG = 1;
  localparam int POS_HS_MUTE = 15;
  localparam int POS_HS_GAIN = 8;
  localparam int POS_HS_TGT = 5;
  localparam int POS_HS_TC = 1;
  localparam int POS_HS_AGC = 0;
  localparam int POS_CP_PD = 15;
  localparam int POS_CP_GAIN = 8;
  localparam int POS_CP_FLAG = 7;
  localparam int POS_BU_PD = 6;
  localparam int POS_BU_GAIN = 2;
  localparam int POS_BU_FLAG = 1;

  // ----------------------------------------------------------------
  // reset values and limits
  // ----------------------------------------------------------------
  localparam logic [13:0] RST_PLL_FRAC = 14'h0000;
  localparam logic [13:0] PLL_FRAC_MAX = 14'h270F;
  localparam logic [4:0]  RST_STEP_OFF = 5'h00;
  localparam logic [1:0]  RST_HYST = 2'h0;
  localparam logic [1:0]  RST_HED_BIAS = 2'h0;
  localparam logic        RST_HND_BIAS = 1'h0;
  localparam logic        RST_HS_MUTE = 1'h1;
  localparam logic [6:0]  RST_HS_GAIN = 7'h7F;
  localparam logic [2:0]  RST_HS_TGT = 3'h0;
  localparam logic [3:0]  RST_HS_TC = 4'h0;
  localparam logic        RST_HS_AGC = 1'h0;
  localparam logic        RST_CP_PD = 1'h1;
  localparam logic [6:0]  RST_CP_GAIN = 7'h45;
  localparam logic [6:0]  CP_GAIN_MAX = 7'h5D;
  localparam logic [6:0]  CP_GAIN_MIN = 7'h00;
  localparam logic        RST_BU_PD = 1'h1;
  localparam logic [3:0]  RST_BU_GAIN = 4'hF;
  localparam logic [6:0]  RST_ST_GAIN = 7'h00;

  // step-off bit order inside the five-bit field
  localparam int SO_BUZ = 0;
  localparam int SO_CELL = 1;
  localparam int SO_SIDE = 2;
  localparam int SO_DAC = 3;
  localparam int SO_INPUT = 4;

  // ----------------------------------------------------------------
  // decoded selections
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    AGR_BIAS_3V3 = 2'h0,
    AGR_BIAS_2V5 = 2'h1,
    AGR_BIAS_2V0 = 2'h2
  } agr_bias_t;

  localparam logic [2:0] HYST_DB_1 = 3'h1;
  localparam logic [2:0] HYST_DB_2 = 3'h2;
  localparam logic [2:0] HYST_DB_4 = 3'h4;
  localparam logic [2:0] HYST_DB_0 = 3'h0;

endpackage : agr_pkg

// *** agr_regs.sv ***
// gain, soft-step, agc and bias control registers with apb access
//
// How it works
// - pll fraction stored 14 bits, clamped to 9999, used only with pll on
// - five step-off bits; zero enables gradual gain stepping
// - sidetone and cellphone gains step one half-dB code per fs tick
// - buzzer gain steps one 3 dB code per fs tick
// - hysteresis code maps to 1, 2, 4 or 0 dB, only with handset agc
// - read-only short circuit flag shows synchronised detector state
// - handset mute bit mutes the input, resets to one
// - handset gain seven bits in half-dB steps, resets to all ones
// - handset agc bit set with handset selected: mute and gain bits read agc gain
// - three-bit agc target level code passed to the agc
// - four-bit agc time constant passed on, rate independent
// - handset agc bit hands pga control to agc
// - cellphone powerdown bit, resets to one
// - cellphone gain code, reset 0 dB, clamped at 12 dB
// - cellphone agc on: gain bits read-only, read agc gain
// - cellphone flag reads one when applied gain equals setting
// - cellphone agc on: flag shows agc saturation instead
// - buzzer powerdown bit, resets to one
// - buzzer attenuation four bits, 3 dB steps, resets to 1111
// - buzzer flag reads one when applied gain equals setting
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps

// ------------------------------------------------------------------
// one gain stepper
// ------------------------------------------------------------------
module agr_stepper #(
  parameter int         W   = 7,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         rst_i,
  // control
  input  wire logic         tick_i,
  input  wire logic         step_off_i,
  input  wire logic         force_i,
  input  wire logic [W-1:0] force_val_i,
  input  wire logic [W-1:0] target_i,
  // applied gain
  output logic      [W-1:0] applied_o
);
  // elaboration-time guard: a one-bit code cannot step
  if (W < 2) begin : g_bad_width
    $error("agr_stepper: width too small");
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      applied_o <= RST;
    end else if (force_i) begin
      applied_o <= force_val_i;
    end else if (step_off_i) begin
      applied_o <= target_i;
    end else if (tick_i && applied_o < target_i) begin
      applied_o <= applied_o + W'(1);
    end else if (tick_i && applied_o > target_i) begin
      applied_o <= applied_o - W'(1);
    end
  end
endmodule : agr_stepper

// ------------------------------------------------------------------
// register bank
// ------------------------------------------------------------------
module agr_regs
  import agr_pkg::*;
(
  // clock and reset
  input  wire logic                 sys_clk_i,
  input  wire logic                 rst_i,
  // apb slave
  input  wire agr_pkg::agr_apb_req_t apb_req_i,
  output agr_pkg::agr_apb_rsp_t      apb_rsp_o,
  // status from the rest of the codec
  input  wire logic                 pll_enable_i,
  input  wire logic                 fs_tick_i,
  input  wire logic                 short_circuit_i,
  input  wire logic                 handset_selected_i,
  input  wire logic [7:0]           handset_agc_gain_i,
  input  wire logic                 cell_agc_on_i,
  input  wire logic [6:0]           cell_agc_gain_i,
  input  wire logic [6:0]           sidetone_gain_i,
  // pll
  output logic      [13:0]          pll_fraction_o,
  // step control to other pgas
  output logic                      input_pga_step_off_o,
  output logic                      dac_pga_step_off_o,
  // mic agc and bias
  output logic      [2:0]           agc_hysteresis_db_o,
  output agr_pkg::agr_bias_t         headset_bias_output_o,
  output agr_pkg::agr_bias_t         handset_bias_output_o,
  // handset pga
  output logic                      handset_input_mute_o,
  output logic      [6:0]           handset_pga_gain_o,
  output logic                      handset_pga_agc_o,
  output logic      [2:0]           handset_agc_target_o,
  output logic      [3:0]           handset_agc_time_const_o,
  // applied gains and powerdown controls
  output logic      [6:0]           sidetone_gain_applied_o,
  output logic                      cellphone_pga_powerdown_o,
  output logic      [6:0]           cellphone_gain_applied_o,
  output logic                      buzzer_pga_powerdown_o,
  output logic      [3:0]           buzzer_gain_applied_o
);
  import agr_pkg::*;

  // ----------------------------------------------------------------
  // apb handshake: one wait state so read data comes from a flop
  // ----------------------------------------------------------------
  logic        access;
  logic        ready;
  logic        wr_en;
  logic        hit;
  logic [31:0] rd_word;
  logic [31:0] prdata;
  logic        pslverr;

  assign access = apb_req_i.psel && apb_req_i.penable;
  assign wr_en = access && ready && apb_req_i.pwrite;
  assign hit = apb_req_i.paddr == ADDR_PLL_FRAC ||
               apb_req_i.paddr == ADDR_STEP_BIAS ||
               apb_req_i.paddr == ADDR_HANDSET ||
               apb_req_i.paddr == ADDR_CELL_BUZ;
  assign apb_rsp_o = '{prdata: prdata, pready: ready, pslverr: pslverr};

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      ready <= access && !ready;
      if (access && !ready) begin
        prdata <= apb_req_i.pwrite ? 32'h0000_0000 : rd_word;
        pslverr <= !hit;
      end
    end
  end

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [13:0] pll_frac;
  logic [4:0]  step_off;
  logic [1:0]  hyst;
  logic [1:0]  hed_bias;
  logic        hnd_bias;
  logic        hs_mute;
  logic [6:0]  hs_gain;
  logic [2:0]  hs_tgt;
  logic [3:0]  hs_tc;
  logic        hs_agc;
  logic        cp_pd;
  logic [6:0]  cp_gain;
  logic        bu_pd;
  logic [3:0]  bu_gain;
  logic [31:0] wd;

  assign wd = apb_req_i.pwdata;

  // reserved bits are never stored, so stray ones do no harm
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pll_frac <= RST_PLL_FRAC;
    end else if (wr_en && apb_req_i.paddr == ADDR_PLL_FRAC) begin
      pll_frac <= wd[POS_PLL_FRAC +: 14];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      step_off <= RST_STEP_OFF;
      hyst <= RST_HYST;
      hed_bias <= RST_HED_BIAS;
      hnd_bias <= RST_HND_BIAS;
    end else if (wr_en && apb_req_i.paddr == ADDR_STEP_BIAS) begin
      step_off <= wd[POS_STEP_OFF +: 5];
      hyst <= wd[POS_HYST +: 2];
      hed_bias <= wd[POS_HED_BIAS +: 2];
      hnd_bias <= wd[POS_HND_BIAS];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      hs_mute <= RST_HS_MUTE;
      hs_gain <= RST_HS_GAIN;
      hs_tgt <= RST_HS_TGT;
      hs_tc <= RST_HS_TC;
      hs_agc <= RST_HS_AGC;
    end else if (wr_en && apb_req_i.paddr == ADDR_HANDSET) begin
      hs_mute <= wd[POS_HS_MUTE];
      hs_gain <= wd[POS_HS_GAIN +: 7];
      hs_tgt <= wd[POS_HS_TGT +: 3];
      hs_tc <= wd[POS_HS_TC +: 4];
      hs_agc <= wd[POS_HS_AGC];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cp_pd <= RST_CP_PD;
      cp_gain <= RST_CP_GAIN;
      bu_pd <= RST_BU_PD;
      bu_gain <= RST_BU_GAIN;
    end else if (wr_en && apb_req_i.paddr == ADDR_CELL_BUZ) begin
      cp_pd <= wd[POS_CP_PD];
      if (!cell_agc_on_i) begin
        cp_gain <= wd[POS_CP_GAIN +: 7];
      end
      bu_pd <= wd[POS_BU_PD];
      bu_gain <= wd[POS_BU_GAIN +: 4];
    end
  end

  // ----------------------------------------------------------------
  // short circuit detector synchroniser
  // ----------------------------------------------------------------
  logic sc_s1;
  logic sc_s2;
  logic sc_s3;
  logic sc_flag;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sc_s1 <= 1'b0;
      sc_s2 <= 1'b0;
      sc_s3 <= 1'b0;
      sc_flag <= 1'b0;
    end else begin
      sc_s1 <= short_circuit_i;
      sc_s2 <= sc_s1;
      sc_s3 <= sc_s2;
      if (sc_s2 == sc_s3) begin
        sc_flag <= sc_s3;
      end
    end
  end

  // ----------------------------------------------------------------
  // soft stepping
  // ----------------------------------------------------------------
  logic [6:0] cp_target;
  logic [6:0] cp_applied;
  logic [6:0] st_applied;
  logic [3:0] bu_applied;
  logic       cp_flag;
  logic       bu_flag;
  logic       cp_sat;

  // codes past the top all mean 12 dB
  assign cp_target = cp_gain > CP_GAIN_MAX ? CP_GAIN_MAX : cp_gain;

  agr_stepper #(.W(7), .RST(RST_CP_GAIN)) u_cell_step (
    .sys_clk_i   (sys_clk_i),
    .rst_i       (rst_i),
    .tick_i      (fs_tick_i),
    .step_off_i  (step_off[SO_CELL]),
    .force_i     (cell_agc_on_i),
    .force_val_i (cell_agc_gain_i),
    .target_i    (cp_target),
    .applied_o   (cp_applied)
  );

  agr_stepper #(.W(7), .RST(RST_ST_GAIN)) u_side_step (
    .sys_clk_i   (sys_clk_i),
    .rst_i       (rst_i),
    .tick_i      (fs_tick_i),
    .step_off_i  (step_off[SO_SIDE]),
    .force_i     (1'b0),
    .force_val_i (7'h00),
    .target_i    (sidetone_gain_i),
    .applied_o   (st_applied)
  );

  agr_stepper #(.W(4), .RST(RST_BU_GAIN)) u_buz_step (
    .sys_clk_i   (sys_clk_i),
    .rst_i       (rst_i),
    .tick_i      (fs_tick_i),
    .step_off_i  (step_off[SO_BUZ]),
    .force_i     (1'b0),
    .force_val_i (4'h0),
    .target_i    (bu_gain),
    .applied_o   (bu_applied)
  );

  assign cp_sat = cp_applied == CP_GAIN_MIN ||
                  cp_applied >= CP_GAIN_MAX;
  assign cp_flag = cell_agc_on_i ? cp_sat
                                 : cp_applied == cp_target;
  assign bu_flag = bu_applied == bu_gain;

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  logic       hs_agc_view;
  logic [7:0] hs_rd;
  logic [6:0] cp_rd;

  assign hs_agc_view = hs_agc && handset_selected_i;
  assign hs_rd = hs_agc_view ? handset_agc_gain_i
                             : {hs_mute, hs_gain};
  assign cp_rd = cell_agc_on_i ? cp_applied : cp_gain;

  always_comb begin
    rd_word = 32'h0000_0000;
    case (apb_req_i.paddr)
      ADDR_PLL_FRAC: begin
        rd_word[POS_PLL_FRAC +: 14] = pll_frac;
      end
      ADDR_STEP_BIAS: begin
        rd_word[POS_STEP_OFF +: 5] = step_off;
        rd_word[POS_HYST +: 2] = hyst;
        rd_word[POS_HED_BIAS +: 2] = hed_bias;
        rd_word[POS_HND_BIAS] = hnd_bias;
        rd_word[POS_SC_FLAG] = sc_flag;
      end
      ADDR_HANDSET: begin
        rd_word[POS_HS_GAIN +: 8] = hs_rd;
        rd_word[POS_HS_TGT +: 3] = hs_tgt;
        rd_word[POS_HS_TC +: 4] = hs_tc;
        rd_word[POS_HS_AGC] = hs_agc;
      end
      ADDR_CELL_BUZ: begin
        rd_word[POS_CP_PD] = cp_pd;
        rd_word[POS_CP_GAIN +: 7] = cp_rd;
        rd_word[POS_CP_FLAG] = cp_flag;
        rd_word[POS_BU_PD] = bu_pd;
        rd_word[POS_BU_GAIN +: 4] = bu_gain;
        rd_word[POS_BU_FLAG] = bu_flag;
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registered control outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pll_fraction_o <= RST_PLL_FRAC;
      agc_hysteresis_db_o <= HYST_DB_0;
      headset_bias_output_o <= AGR_BIAS_3V3;
      handset_bias_output_o <= AGR_BIAS_2V5;
    end else begin
      // value only meaningful with the pll running
      if (!pll_enable_i) begin
        pll_fraction_o <= RST_PLL_FRAC;
      end else if (pll_frac > PLL_FRAC_MAX) begin
        pll_fraction_o <= PLL_FRAC_MAX;
      end else begin
        pll_fraction_o <= pll_frac;
      end
      if (!hs_agc) begin
        agc_hysteresis_db_o <= HYST_DB_0;
      end else begin
        case (hyst)
          2'h0: agc_hysteresis_db_o <= HYST_DB_1;
          2'h1: agc_hysteresis_db_o <= HYST_DB_2;
          2'h2: agc_hysteresis_db_o <= HYST_DB_4;
          default: agc_hysteresis_db_o <= HYST_DB_0;
        endcase
      end
      case (hed_bias)
        2'h0: headset_bias_output_o <= AGR_BIAS_3V3;
        2'h1: headset_bias_output_o <= AGR_BIAS_2V5;
        default: headset_bias_output_o <= AGR_BIAS_2V0;
      endcase
      handset_bias_output_o <= hnd_bias ? AGR_BIAS_2V0
                                        : AGR_BIAS_2V5;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      input_pga_step_off_o <= RST_STEP_OFF[SO_INPUT];
      dac_pga_step_off_o <= RST_STEP_OFF[SO_DAC];
      handset_input_mute_o <= RST_HS_MUTE;
      handset_pga_gain_o <= RST_HS_GAIN;
      handset_pga_agc_o <= RST_HS_AGC;
      handset_agc_target_o <= RST_HS_TGT;
      handset_agc_time_const_o <= RST_HS_TC;
    end else begin
      input_pga_step_off_o <= step_off[SO_INPUT];
      dac_pga_step_off_o <= step_off[SO_DAC];
      handset_input_mute_o <= hs_mute;
      handset_pga_gain_o <= hs_gain;
      handset_pga_agc_o <= hs_agc;
      handset_agc_target_o <= hs_tgt;
      handset_agc_time_const_o <= hs_tc;
    end
  end

  assign sidetone_gain_applied_o = st_applied;
  assign cellphone_gain_applied_o = cp_applied;
  assign buzzer_gain_applied_o = bu_applied;
  assign cellphone_pga_powerdown_o = cp_pd;
  assign buzzer_pga_powerdown_o = bu_pd;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence hs_wr_s;
    wr_en && apb_req_i.paddr == ADDR_HANDSET;
  endsequence

  sequence cell_step_s;
    fs_tick_i && !step_off[SO_CELL] && !cell_agc_on_i &&
      cp_applied != cp_target;
  endsequence

  pll_clamp_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    pll_enable_i && pll_frac > PLL_FRAC_MAX |=> pll_fraction_o == PLL_FRAC_MAX)
    else $error("pll fraction not clamped");

  cell_step_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    cell_step_s |=> (cp_applied == $past(cp_applied) + 7'h01) ||
                    (cp_applied == $past(cp_applied) - 7'h01))
    else $error("cell gain did not move one step");

  buz_hold_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    !fs_tick_i && !step_off[SO_BUZ] |=> $stable(bu_applied))
    else $error("buzzer gain moved without a tick");

  direct_apply_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    step_off[SO_BUZ] ##1 step_off[SO_BUZ] |-> bu_applied == $past(bu_gain)
      && bu_flag == (bu_gain == $past(bu_gain)))
    else $error("buzzer gain not applied at once");

  sc_sync_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    short_circuit_i [*4] |=> sc_flag)
    else $error("short circuit flag missed");

  reset_vals_a: assert property (
    @(posedge sys_clk_i)
    rst_i |=> hs_mute && cp_pd && bu_pd && hs_gain == RST_HS_GAIN)
    else $error("wrong value after reset");

  hs_write_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    hs_wr_s |=> hs_gain == $past(wd[POS_HS_GAIN +: 7]) ##1
               handset_pga_gain_o == $past(hs_gain))
    else $error("handset gain write lost");

  cell_ro_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    cell_agc_on_i |=> $stable(cp_gain))
    else $error("cell gain written while agc on");

  cell_flag_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    !cell_agc_on_i && cp_applied != cp_target |-> !cp_flag)
    else $error("cell flag set while stepping");

  agc_hand_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    $rose(hs_agc) |=> handset_pga_agc_o)
    else $error("agc did not take the pga");

endmodule : agr_regs

// *** agr_regs_tb.sv ***
// self-checking bench for the gain and agc register bank
`timescale 1ns/1ps
module tb;
  import agr_pkg::*;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic         sys_clk = 1'b0;
  logic         rst     = 1'b1;
  agr_apb_req_t req     = '0;
  agr_apb_rsp_t rsp;
  logic         pll_en  = 1'b0;
  logic         tick    = 1'b0;
  logic         sc      = 1'b0;
  logic         hs_sel  = 1'b0;
  logic [6:0]   st_gain = 7'h00;
  logic         cell_agc  = 1'b0;
  logic [6:0]   cell_gain = 7'h00;
  logic [13:0]  pll_o;
  logic         in_so, dac_so, hs_mute, hs_agc, cp_pd, bu_pd, err;
  logic [2:0]   hyst, hs_tgt;
  logic [3:0]   hs_tc, bu_app;
  logic [6:0]   hs_pga, st_app, cp_app;
  agr_bias_t    hed_b, hnd_b;
  logic [31:0]  rd;
  logic [2:0]   hy[4] = '{3'h1, 3'h2, 3'h4, 3'h0};
  logic [1:0]   hb[4] = '{2'h0, 2'h1, 2'h2, 2'h2};
  int           bad_count = 0;
  int           n_compared = 0;
  int           cyc = 0;

  always #12.5 sys_clk = ~sys_clk;

  // handset agc gain held at the -12 dB code for the readback check
  agr_regs dut (
    .sys_clk_i(sys_clk), .rst_i(rst), .apb_req_i(req), .apb_rsp_o(rsp),
    .pll_enable_i(pll_en), .fs_tick_i(tick), .short_circuit_i(sc),
    .handset_selected_i(hs_sel), .handset_agc_gain_i(8'hE8),
    .cell_agc_on_i(cell_agc), .cell_agc_gain_i(cell_gain),
    .sidetone_gain_i(st_gain), .pll_fraction_o(pll_o),
    .input_pga_step_off_o(in_so), .dac_pga_step_off_o(dac_so),
    .agc_hysteresis_db_o(hyst), .headset_bias_output_o(hed_b),
    .handset_bias_output_o(hnd_b), .handset_input_mute_o(hs_mute),
    .handset_pga_gain_o(hs_pga), .handset_pga_agc_o(hs_agc),
    .handset_agc_target_o(hs_tgt), .handset_agc_time_const_o(hs_tc),
    .sidetone_gain_applied_o(st_app), .cellphone_pga_powerdown_o(cp_pd),
    .cellphone_gain_applied_o(cp_app), .buzzer_pga_powerdown_o(bu_pd),
    .buzzer_gain_applied_o(bu_app)
  );

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    if (bad_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // pready is sampled before the edge's own updates land
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge sys_clk);
    req.penable <= 1'b1;
    do @(posedge sys_clk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask : apb

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdc

  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : wt

  task automatic pulse();
    @(posedge sys_clk);
    tick <= 1'b1;
    @(posedge sys_clk);
    tick <= 1'b0;
    wt(1);
  endtask : pulse

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      bad_count++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    wt(6);
    rst <= 1'b0;
    wt(1);
    chk(32'({hs_mute, cp_pd, bu_pd, hyst, hs_pga, cp_app, bu_app}),
        32'hE3FC5F);
    rdc(ADDR_HANDSET, 32'h0000FF00);
    rdc(ADDR_CELL_BUZ, 32'h0000C5FE);
    rdc(ADDR_STEP_BIAS, 32'h0);
    rdc(8'h00, 32'h0);
    chk(32'(err), 32'h1);
    apb(1'b1, ADDR_PLL_FRAC, 32'h0000FFFC);
    rdc(ADDR_PLL_FRAC, 32'h0000FFFC);
    pll_en <= 1'b1;
    wt(3);
    chk(32'(pll_o), 32'h270F);
    pll_en <= 1'b0;
    wt(3);
    chk(32'(pll_o), 32'h0);
    apb(1'b1, ADDR_HANDSET, 32'h00000A5B);
    wt(3);
    chk(32'({hs_mute, hs_pga, hs_tgt, hs_tc, hs_agc}),
        32'h0A5B);
    rdc(ADDR_HANDSET, 32'h0A5B);
    hs_sel <= 1'b1;
    rdc(ADDR_HANDSET, 32'hE85B);
    hs_sel <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, ADDR_STEP_BIAS, 32'(i * 32'h280 + (i % 2) * 32'h40));
      wt(3);
      chk(32'({hyst, hed_b, hnd_b}),
          32'({hy[i], hb[i], (i % 2 == 1) ? 2'h2 : 2'h1}));
      rdc(ADDR_STEP_BIAS, 32'(i * 32'h280 + (i % 2) * 32'h40));
    end
    sc <= 1'b1;
    wt(6);
    rdc(ADDR_STEP_BIAS, 32'h7C2);
    sc <= 1'b0;
    // stepping on: nothing moves until a sample tick
    st_gain <= 7'h02;
    apb(1'b1, ADDR_CELL_BUZ, 32'h4734);
    wt(2);
    chk(32'({cp_pd, bu_pd, cp_app, bu_app}),
        32'h045F);
    rdc(ADDR_CELL_BUZ, 32'h4734);
    pulse();
    chk(32'({st_app, cp_app, bu_app}), 32'h00C6E);
    pulse();
    chk(32'({st_app, cp_app, bu_app}), 32'h0147D);
    rdc(ADDR_CELL_BUZ, 32'h47B6);
    apb(1'b1, ADDR_STEP_BIAS, 32'hD800);
    wt(2);
    chk(32'({in_so, dac_so}), 32'h3);
    apb(1'b1, ADDR_CELL_BUZ, 32'hFF40);
    wt(3);
    chk(32'({cp_app, bu_app}), 32'h5D0);
    // cell agc owns the gain: gain writes ignored, flag shows saturation
    cell_agc <= 1'b1;
    cell_gain <= 7'h20;
    apb(1'b1, ADDR_CELL_BUZ, 32'h3040);
    rdc(ADDR_CELL_BUZ, 32'h2042);
    cell_gain <= 7'h00;
    rdc(ADDR_CELL_BUZ, 32'h00C2);
    cell_agc <= 1'b0;
    rdc(ADDR_CELL_BUZ, 32'h7FC2);
    finish_test();
  end
endmodule : tb
